// >>> ife_pkg.sv
`default_nettype none

package ife_pkg;

    // ************************************************************
    // Field positions, numbered from 0 at the most significant bit
    // ************************************************************
    localparam int IFE_OPCODE_FIRST   = 0;
    localparam int IFE_OPCODE_LAST    = 5;
    localparam int IFE_FSMASK_FIRST   = 7;
    localparam int IFE_FSMASK_LAST    = 14;
    localparam int IFE_FRA_FIRST      = 11;
    localparam int IFE_FRA_LAST       = 15;
    localparam int IFE_FRB_FIRST      = 16;
    localparam int IFE_FRB_LAST       = 20;
    localparam int IFE_FRC_FIRST      = 21;
    localparam int IFE_FRC_LAST       = 25;
    localparam int IFE_FRDS_FIRST     = 6;
    localparam int IFE_FRDS_LAST      = 10;
    localparam int IFE_FSIMM_FIRST    = 16;
    localparam int IFE_FSIMM_LAST     = 19;
    localparam int IFE_DISP_FIRST     = 6;
    localparam int IFE_DISP_LAST      = 29;
    localparam int IFE_LINK_BIT       = 31;
    localparam int IFE_MBEGIN_FIRST   = 21;
    localparam int IFE_MBEGIN_LAST    = 25;
    localparam int IFE_MEND_FIRST     = 26;
    localparam int IFE_MEND_LAST      = 30;
    localparam int IFE_NBYTES_FIRST   = 16;
    localparam int IFE_NBYTES_LAST    = 20;
    localparam int IFE_OVEN_BIT       = 21;
    localparam int IFE_GPRA_FIRST     = 11;
    localparam int IFE_GPRA_LAST      = 15;

    // ************************************************************
    // Arithmetic constants and reset values
    // ************************************************************
    localparam logic [31:0] IFE_INSN_BYTES = 32'h0000_0004;
    localparam logic [31:0] IFE_RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [5:0]  opcode;
        logic [7:0]  fp_status_field_mask;
        logic [4:0]  fp_src_a_spec;
        logic [4:0]  fp_src_b_spec;
        logic [4:0]  fp_src_c_spec;
        logic [4:0]  fp_dest_spec;
        logic [4:0]  fp_store_src_spec;
        logic [3:0]  fp_status_immediate;
        logic [31:0] long_branch_disp;
        logic        link_update_bit;
        logic [4:0]  mask_begin;
        logic [4:0]  mask_end;
        logic [31:0] rotate_mask;
        logic [4:0]  string_byte_count;
        logic        overflow_enable;
        logic [4:0]  gp_reg_a_spec;
    } ife_fields_type;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
    } ife_link_type;

endpackage

`default_nettype wire

// >>> ife_insn_field_extract.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Status field mask from bits 7..14
// - FP sources from 11..15, 16..20, 21..25
// - FP destination and store source from 6..10
// - Four-bit status immediate from bits 16..19
// - 24-bit displacement, append 00, sign-extend
// - Bit 31 on branch writes next address
// - Rotate mask ones from begin through end
// - String byte count from bits 16..20
// - Bit 21 on extended arithmetic enables overflow flag updates
// - General register specifier from bits 11..15
module ife_insn_field_extract
    import ife_pkg::*;
(
    input  wire logic           CLK,
    input  wire logic           RST_B,
    input  wire logic           INSN_VALID,
    input  wire logic [31:0]    INSN,
    input  wire logic [31:0]    INSN_ADDR,
    input  wire logic           IS_BRANCH,
    input  wire logic           IS_EXT_ARITH,
    output var  logic           FIELDS_VALID,
    output var  ife_fields_type FIELDS,
    output var  ife_link_type   LINK
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Right-justified field between big-endian positions first..last
    function automatic logic [31:0] ife_field(input logic [31:0] word,
                                              input int          first,
                                              input int          last);
        logic [31:0] result;
        result = '0;
        for (int i = first; i <= last; i++) begin
            result[last - i] = word[31 - i];
        end
        return result;
    endfunction

    function automatic logic ife_bit(input logic [31:0] word, input int pos);
        return word[31 - pos];
    endfunction

    // Ones from big-endian position mb through me; wraps when mb > me
    function automatic logic [31:0] ife_rot_mask(input logic [4:0] mb,
                                                 input logic [4:0] me);
        logic [31:0] mask;
        mask = '0;
        for (int i = 0; i < 32; i++) begin
            if (mb <= me) begin
                mask[31 - i] = (i >= int'(mb)) && (i <= int'(me));
            end else begin
                mask[31 - i] = (i >= int'(mb)) || (i <= int'(me));
            end
        end
        return mask;
    endfunction

    // ************************************************************
    // Field arithmetic
    // ************************************************************
    // Sign-extended byte displacement from the 24-bit word offset
    function automatic logic [31:0] ife_sext_disp(input logic [23:0] offset);
        logic [31:0] result;
        result = {{6{offset[23]}}, offset, 2'b00};
        return result;
    endfunction

    // Address of the following instruction; wraps at the top of memory
    function automatic logic [31:0] ife_next_addr(input logic [31:0] addr);
        logic [31:0] result;
        result = addr + IFE_INSN_BYTES;
        return result;
    endfunction

    // ************************************************************
    // Raw fields
    // ************************************************************
    logic [5:0]  raw_opcode;
    logic [7:0]  raw_fsmask;
    logic [4:0]  raw_fra;
    logic [4:0]  raw_frb;
    logic [4:0]  raw_frc;
    logic [4:0]  raw_frds;
    logic [3:0]  raw_fsimm;
    logic [23:0] raw_disp;
    logic        raw_link;
    logic [4:0]  raw_mbegin;
    logic [4:0]  raw_mend;
    logic [4:0]  raw_nbytes;
    logic        raw_oven;
    logic [4:0]  raw_gpra;
    logic [31:0] raw_rot_mask;

    always_comb begin
        // Every field is cut here once and shared by the groups below
        raw_opcode = 6'(ife_field(INSN, IFE_OPCODE_FIRST,
                                  IFE_OPCODE_LAST));
        raw_fsmask = 8'(ife_field(INSN, IFE_FSMASK_FIRST,
                                  IFE_FSMASK_LAST));
        raw_fra    = 5'(ife_field(INSN, IFE_FRA_FIRST,
                                  IFE_FRA_LAST));
        raw_frb    = 5'(ife_field(INSN, IFE_FRB_FIRST,
                                  IFE_FRB_LAST));
        raw_frc    = 5'(ife_field(INSN, IFE_FRC_FIRST,
                                  IFE_FRC_LAST));
        raw_frds   = 5'(ife_field(INSN, IFE_FRDS_FIRST,
                                  IFE_FRDS_LAST));
        raw_fsimm  = 4'(ife_field(INSN, IFE_FSIMM_FIRST,
                                  IFE_FSIMM_LAST));
        raw_disp   = 24'(ife_field(INSN, IFE_DISP_FIRST,
                                   IFE_DISP_LAST));
        raw_mbegin = 5'(ife_field(INSN, IFE_MBEGIN_FIRST,
                                  IFE_MBEGIN_LAST));
        raw_mend   = 5'(ife_field(INSN, IFE_MEND_FIRST,
                                  IFE_MEND_LAST));
        raw_nbytes = 5'(ife_field(INSN, IFE_NBYTES_FIRST,
                                  IFE_NBYTES_LAST));
        raw_gpra   = 5'(ife_field(INSN, IFE_GPRA_FIRST,
                                  IFE_GPRA_LAST));
        raw_link   = ife_bit(INSN, IFE_LINK_BIT);
        raw_oven   = ife_bit(INSN, IFE_OVEN_BIT);
    end

    always_comb begin
        // Begin past end gives a wrapped mask, as rotates need
        raw_rot_mask = ife_rot_mask(raw_mbegin, raw_mend);
    end

    // ************************************************************
    // Valid pulse
    // ************************************************************
    logic next_valid;

    always_comb begin
        next_valid = INSN_VALID;
    end

    // Registered so the pulse lines up with the fields
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            FIELDS_VALID <= 1'b0;
        end else begin
            FIELDS_VALID <= next_valid;
        end
    end

    // ************************************************************
    // Instruction fields
    // ************************************************************
    ife_fields_type next_fields;

    always_comb begin
        next_fields = FIELDS;
        // Fields hold their last value between instructions so the
        // execute stage sees no glitching operands while stalled
        if (INSN_VALID) begin
            next_fields.opcode               = raw_opcode;
            next_fields.fp_status_field_mask = raw_fsmask;
            next_fields.fp_src_a_spec        = raw_fra;
            next_fields.fp_src_b_spec        = raw_frb;
            next_fields.fp_src_c_spec        = raw_frc;
            next_fields.fp_dest_spec         = raw_frds;
            next_fields.fp_store_src_spec    = raw_frds;
            next_fields.fp_status_immediate  = raw_fsimm;
            next_fields.long_branch_disp     = ife_sext_disp(raw_disp);
            next_fields.link_update_bit      = raw_link;
            next_fields.mask_begin           = raw_mbegin;
            next_fields.mask_end             = raw_mend;
            next_fields.rotate_mask          = raw_rot_mask;
            next_fields.string_byte_count    = raw_nbytes;
            next_fields.overflow_enable      = IS_EXT_ARITH && raw_oven;
            next_fields.gp_reg_a_spec        = raw_gpra;
        end
    end

    // No enable here: the hold lives in the next-value logic
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            FIELDS <= '0;
        end else begin
            FIELDS <= next_fields;
        end
    end

    // ************************************************************
    // Link register request
    // ************************************************************
    ife_link_type next_link;

    always_comb begin
        // Write is a pulse; the address holds for a late consumer
        next_link.write = 1'b0;
        next_link.addr  = LINK.addr;
        if (INSN_VALID) begin
            // Link register left untouched unless a branch sets the bit
            next_link.write = IS_BRANCH && raw_link;
            next_link.addr  = ife_next_addr(INSN_ADDR);
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            LINK.write <= 1'b0;
            LINK.addr  <= IFE_RESET_WORD;
        end else begin
            LINK <= next_link;
        end
    end

endmodule

`default_nettype wire

// >>> ife_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Field relations one cycle after a take
// ****************************************
module ife_assertions
    import ife_pkg::*;
(
    input wire logic           CLK,
    input wire logic           RST_B,
    input wire logic           INSN_VALID,
    input wire logic [31:0]    INSN,
    input wire logic [31:0]    INSN_ADDR,
    input wire logic           IS_BRANCH,
    input wire logic           IS_EXT_ARITH,
    input wire logic           FIELDS_VALID,
    input wire ife_fields_type FIELDS,
    input wire ife_link_type   LINK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Pulse must follow the take, otherwise the field checks below stay silent
    sequence s_take; INSN_VALID ##1 FIELDS_VALID; endsequence
    property p_mask; s_take |-> FIELDS.fp_status_field_mask == $past(INSN[24:17]); endproperty
    property p_fsrc; s_take |-> {FIELDS.fp_src_a_spec, FIELDS.fp_src_b_spec,
        FIELDS.fp_src_c_spec} == $past(INSN[20:6]); endproperty
    property p_fdst; s_take |-> FIELDS.fp_dest_spec == $past(INSN[25:21])
        && FIELDS.fp_store_src_spec == $past(INSN[25:21]); endproperty
    property p_disp; s_take |-> FIELDS.long_branch_disp
        == {{6{$past(INSN[25])}}, $past(INSN[25:2]), 2'h0}; endproperty
    property p_link; s_take |-> LINK.write == ($past(IS_BRANCH) && $past(INSN[0]))
        && LINK.addr == $past(INSN_ADDR) + 32'h4; endproperty
    property p_ov; s_take |-> FIELDS.overflow_enable
        == ($past(IS_EXT_ARITH) && $past(INSN[10])); endproperty
    property p_imm; s_take |-> {FIELDS.fp_status_immediate, FIELDS.string_byte_count}
        == {$past(INSN[15:12]), $past(INSN[15:11])}; endproperty
    property p_gpr; s_take |-> FIELDS.gp_reg_a_spec == $past(INSN[20:16])
        && FIELDS.opcode == $past(INSN[31:26]); endproperty
    property p_rot; s_take |-> FIELDS.mask_begin == $past(INSN[10:6])
        && FIELDS.mask_end == $past(INSN[5:1]); endproperty
    property p_lbit; s_take |-> FIELDS.link_update_bit == $past(INSN[0]); endproperty
    a_rot: assert property (p_rot) else $error("mask bounds wrong");
    a_lbit: assert property (p_lbit) else $error("link bit wrong");
    a_mask: assert property (p_mask) else $error("status mask wrong");
    a_fsrc: assert property (p_fsrc) else $error("fp sources wrong");
    a_fdst: assert property (p_fdst) else $error("fp dest wrong");
    a_disp: assert property (p_disp) else $error("displacement wrong");
    a_link: assert property (p_link) else $error("link wrong");
    a_ov: assert property (p_ov) else $error("overflow enable wrong");
    a_imm: assert property (p_imm) else $error("imm or count wrong");
    a_gpr: assert property (p_gpr) else $error("gpr or opcode wrong");
endmodule

bind ife_insn_field_extract ife_assertions u_chk (.CLK, .RST_B, .INSN_VALID, .INSN,
    .INSN_ADDR, .IS_BRANCH, .IS_EXT_ARITH, .FIELDS_VALID, .FIELDS, .LINK);
`default_nettype wire

// >>> ife_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Fetch side: one word per send, released after
// ****************************************
module ife_fetch_model (
    input wire logic     clk,
    output logic         valid,
    output logic [31:0]  word,
    output logic [31:0]  addr,
    output logic         br,
    output logic         ea
);
    initial {valid, word, addr, br, ea} = '0;
    task automatic send(input logic [31:0] w, a, input logic b, e);
        @(negedge clk);
        {valid, word, addr, br, ea} = {1'b1, w, a, b, e};
        @(negedge clk);
        // Inverted leftovers so a design that samples idle words is caught
        {valid, word, addr, br, ea} = {1'b0, ~w, ~a, ~b, ~e};
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Scenario tasks and verdict
// ****************************************
module tb import ife_pkg::*;;
    logic           CLK = 1'b0, RST_B = 1'b0, iv, br, ea, fv;
    logic [31:0]    w, a;
    ife_fields_type f;
    ife_link_type   lk;
    int             failures = 0, checks_done = 0;
    always #10 CLK = ~CLK;
    ife_fetch_model fm (.clk(CLK), .valid(iv), .word(w), .addr(a), .br(br), .ea(ea));
    ife_insn_field_extract DUT (.CLK, .RST_B, .INSN_VALID(iv), .INSN(w), .INSN_ADDR(a),
        .IS_BRANCH(br), .IS_EXT_ARITH(ea), .FIELDS_VALID(fv), .FIELDS(f), .LINK(lk));
    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic issue(input logic [31:0] wd, ad, input logic b, e);
        fm.send(wd, ad, b, e);
        for (int n = 0; n < 4 && fv !== 1'b1; n++) @(negedge CLK);
        chk("fields_valid", fv, 1'b1);
        if (fv !== 1'b1) complete_run;
    endtask
    function automatic logic [31:0] rmask(input int mb, me);
        logic [31:0] m;
        for (int b = 0; b < 32; b++) m[31-b] = mb <= me ? b >= mb && b <= me : b >= mb || b <= me;
        return m;
    endfunction
    task automatic t_fields(input logic [31:0] x);
        issue(x, 32'h0, 1'b0, 1'b0);
        chk("opcode", f.opcode, x[31:26]);
        chk("fsmask", f.fp_status_field_mask, x[24:17]);
        chk("fsrc", {f.fp_src_a_spec, f.fp_src_b_spec, f.fp_src_c_spec}, x[20:6]);
        chk("fdest", f.fp_dest_spec, x[25:21]);
        chk("fstore", f.fp_store_src_spec, x[25:21]);
        chk("fsimm", f.fp_status_immediate, x[15:12]);
        chk("disp", f.long_branch_disp, {{6{x[25]}}, x[25:2], 2'h0});
        chk("nbytes", f.string_byte_count, x[15:11]);
        chk("gpr_a", f.gp_reg_a_spec, x[20:16]);
        $display("fields test done");
    endtask
    task automatic t_link;
        // Address at the top of memory checks the wrap of the next address
        for (int k = 0; k < 4; k++) begin
            issue({21'h0, k[0], 9'h0, k[0]}, 32'hfffffffc, k[1], k[1]);
            chk("link_bit", f.link_update_bit, k[0]);
            chk("link_wr", lk.write, k[1] & k[0]);
            chk("link_addr", lk.addr, 32'h0);
            chk("ov_en", f.overflow_enable, k[1] & k[0]);
        end
        $display("link test done");
    endtask
    task automatic t_rotate;
        int mb [4] = '{0, 5, 30, 31};
        int me [4] = '{31, 5, 2, 0};
        for (int k = 0; k < 4; k++) begin
            issue({21'h0, 5'(mb[k]), 5'(me[k]), 1'b0}, 32'h0, 1'b0, 1'b0);
            chk("mask_begin", f.mask_begin, mb[k]);
            chk("mask_end", f.mask_end, me[k]);
            chk("rot_mask", f.rotate_mask, rmask(mb[k], me[k]));
        end
        $display("rotate test done");
    endtask
    task automatic t_hold;
        issue(32'hffffffff, 32'h0, 1'b1, 1'b1);
        repeat (3) @(negedge CLK);
        chk("valid_low", fv, 1'b0);
        chk("write_low", lk.write, 1'b0);
        chk("held_mask", f.fp_status_field_mask, 8'hff);
        chk("held_addr", lk.addr, 32'h4);
        $display("hold test done");
    endtask
    initial begin
        repeat (6) @(negedge CLK);
        chk("reset_valid", fv, 1'b0);
        chk("reset_write", lk.write, 1'b0);
        chk("reset_addr", lk.addr, 32'h0);
        chk("reset_mask", f.rotate_mask, 32'h0);
        RST_B = 1'b1;
        t_fields(32'h5a5aa5a5);
        t_fields(32'ha5a55a5a);
        t_link;
        t_rotate;
        t_hold;
        complete_run;
    end
endmodule
`default_nettype wire
